// ### design/tws_consts.svh
// Constant definitions for the two-wire memory slave.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// Slave address field positions.
`define TWS_SA_TYPE_MSB 7
`define TWS_SA_TYPE_LSB 4
`define TWS_SA_SEL_MSB  3
`define TWS_SA_SEL_LSB  1
`define TWS_SA_DIR_BIT  0

// High speed master code: upper five bits of the byte.
`define TWS_HS_CODE     5'h01

// Bit counter value of the acknowledge slot, and of the last data bit.
`define TWS_ACK_SLOT    4'h8
`define TWS_LAST_BIT    4'h7

// Reset values.
`define TWS_ADDR_RST    16'h0000
`define TWS_BITCNT_RST  4'h0

`endif

// ### design/tws_pkg.sv
// Types shared by the two-wire memory slave.
// Assumes the constants header is on the include path.
`include "tws_consts.svh"

package tws_pkg;

   // Protocol phase of the link engine, one-hot.
   typedef enum logic [5:0] {
      TWS_ST_SLADDR = 6'h01,
      TWS_ST_ADRHI  = 6'h02,
      TWS_ST_ADRLO  = 6'h04,
      TWS_ST_WRDATA = 6'h08,
      TWS_ST_RDDATA = 6'h10,
      TWS_ST_IGNORE = 6'h20
   } tws_state_t;

   // Fields of the slave address byte, most significant first.
   typedef struct packed {
      logic [3:0] devType;
      logic [2:0] devSel;
      logic       dirRead;
   } tws_sladdr_t;

   // Bus condition events seen in the reference domain.
   typedef struct packed {
      logic start;
      logic stop;
   } tws_cond_t;

endpackage : tws_pkg

// ### design/tws_mem_slave.sv
// Two-wire bus slave front end with a byte memory behind it.
// Assumes an external pull-up on the data line, a master that makes scl,
// and a free-running ref_clk well above the bus clock rate.
//
// Behaviour
// RULE1 - Receiver pulls data low in ninth clock.
// RULE2 - Unacknowledged byte aborts, await new address.
// RULE3 - Read: eight bits, master ack continues, nack ends.
// RULE4 - Upper four address bits must match device type.
// RULE5 - Address bits three to one match select pins.
// RULE6 - Address bit zero: one reads, zero writes.
// RULE7 - Master code enters high speed mode.
// RULE8 - Stop leaves high speed mode.
// RULE9 - Two address bytes load fifteen-bit latch.
// RULE10 - Latch holds until rewritten; reads start there.
// RULE11 - Latch increments before each data acknowledge.
// RULE12 - Latch wraps past last location to zero.
// RULE13 - Unlimited bytes per transfer, no page buffer.
// RULE14 - Write: receive eight bits, then acknowledge.
// RULE15 - All bytes shift most significant bit first.
// RULE16 - Commit after eighth bit; earlier abort keeps memory.
// RULE17 - No write delay; device always ready.
// RULE18 - Protect pin high: no writes, no acknowledge.
// RULE19 - Protected write does not increment latch.
// RULE20 - Read data starts on the next clock.
// RULE21 - Master ends read by nack or condition.
// RULE22 - Master must not acknowledge final wanted byte.
// RULE23 - Stop aborts any operation in progress.
// RULE24 - Start aborts operation, awaits slave address.
// RULE25 - Address latch is zero after power-on.
`include "tws_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tws_mem_slave
   import tws_pkg::*;
#(
   parameter int         ADDR_W   = 15,
   // Device type code; the default value is arbitrary.
   parameter logic [3:0] DEV_TYPE = 4'h5
) (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       scl,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic [2:0] device_select_pins,
   input  wire logic       wp,
   output logic            hsMode
);

   localparam int DEPTH = 2 ** ADDR_W;
   localparam int HI_W  = ADDR_W - 8;

   generate
      if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
         $error("ADDR_W must lie between 9 and 16");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Reference domain: power-on reset and bus condition detection.
   ////////////////////////////////////////////////////////////////////////

   logic      porS1_ff;
   logic      porRstN_ff;
   logic      sclS1_ff;
   logic      sclS2_ff;
   logic      sclPrev_ff;
   logic      sdaS1_ff;
   logic      sdaS2_ff;
   logic      sdaPrev_ff;
   logic      inFrame_ff;
   logic      startHold_ff;
   logic      engRstN_ff;
   logic      hsRstN_ff;
   logic      hsS1_ff;
   logic      hsS2_ff;
   tws_cond_t cond;
   logic      nxt_inFrame;
   logic      nxt_startHold;
   logic      nxt_engRstN;
   logic      nxt_hsRstN;
   logic      sclHighSteady;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         porS1_ff   <= 1'b0;
         porRstN_ff <= 1'b0;
      end else begin
         porS1_ff   <= 1'b1;
         porRstN_ff <= porS1_ff;
      end
   end

   // Both bus lines are pins, so each passes two flops before use.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sclS1_ff   <= 1'b1;
         sclS2_ff   <= 1'b1;
         sclPrev_ff <= 1'b1;
         sdaS1_ff   <= 1'b1;
         sdaS2_ff   <= 1'b1;
         sdaPrev_ff <= 1'b1;
      end else begin
         sclS1_ff   <= scl;
         sclS2_ff   <= sclS1_ff;
         sclPrev_ff <= sclS2_ff;
         sdaS1_ff   <= sda_i;
         sdaS2_ff   <= sdaS1_ff;
         sdaPrev_ff <= sdaS2_ff;
      end
   end

   assign sclHighSteady = sclS2_ff && sclPrev_ff;
   assign cond = '{start: sclHighSteady && sdaPrev_ff && !sdaS2_ff,
                   stop:  sclHighSteady && !sdaPrev_ff && sdaS2_ff};

   // A stop ends the frame; a start opens one, even a repeated one.
   assign nxt_inFrame   = cond.start ? 1'b1 :
                          cond.stop  ? 1'b0 : inFrame_ff;
   assign nxt_startHold = cond.start ? 1'b1 :
                          !sclS2_ff  ? 1'b0 : startHold_ff;

   // The engine is held in reset outside frames and through each start
   // until scl is seen low. Release therefore falls in the low phase of
   // scl, well clear of the next rising edge, which makes this a safe
   // crossing into a clock that stands still between frames.
   assign nxt_engRstN   = porRstN_ff && nxt_inFrame && !nxt_startHold; // see RULE23 see RULE24
   assign nxt_hsRstN    = porRstN_ff && nxt_inFrame; // see RULE8

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         inFrame_ff   <= 1'b0;
         startHold_ff <= 1'b0;
         engRstN_ff   <= 1'b0;
         hsRstN_ff    <= 1'b0;
      end else begin
         inFrame_ff   <= nxt_inFrame;
         startHold_ff <= nxt_startHold;
         engRstN_ff   <= nxt_engRstN;
         hsRstN_ff    <= nxt_hsRstN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: pin synchronisers and storage.
   ////////////////////////////////////////////////////////////////////////

   logic [2:0]        selS1_ff;
   logic [2:0]        selS2_ff;
   logic              wpS1_ff;
   logic              wpS2_ff;
   logic [7:0]        memArray [DEPTH];
   logic [ADDR_W-1:0] addrLatch_ff;
   logic [HI_W-1:0]   addrHi_ff;
   logic              hsMode_ff;

   // Select and protect pins are static in use, so sampling them on scl
   // is enough; they settle long before the first byte completes.
   always_ff @(posedge scl or negedge porRstN_ff) begin
      if (!porRstN_ff) begin
         selS1_ff <= 3'h0;
         selS2_ff <= 3'h0;
         wpS1_ff  <= 1'b0;
         wpS2_ff  <= 1'b0;
      end else begin
         selS1_ff <= device_select_pins;
         selS2_ff <= selS1_ff;
         wpS1_ff  <= wp;
         wpS2_ff  <= wpS1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: byte engine, sampled on the rising edge of scl.
   ////////////////////////////////////////////////////////////////////////

   tws_state_t        state_ff;
   tws_state_t        nxt_state;
   logic [3:0]        bitCnt_ff;
   logic [3:0]        nxt_bitCnt;
   logic [7:0]        rxSh_ff;
   logic [7:0]        txSh_ff;
   logic              ackNext_ff;
   logic              dirRead_ff;
   logic              sdaOe_ff;
   logic [7:0]        rxByte;
   tws_sladdr_t       slAddr;
   logic              lastBit;
   logic              ackSlot;
   logic              saMatch;
   logic              isMasterCode;
   logic              wrAllowed;
   logic              ackDecide;
   logic              memWrite;
   logic              addrInc;
   logic              addrLoad;
   logic              txLoad;
   logic              masterAck;
   logic [2:0]        txIdx;
   logic              txBit;
   logic [ADDR_W-1:0] addrPlus;
   logic              driveLow;

   assign rxByte       = {rxSh_ff[6:0], sda_i}; // see RULE15
   assign slAddr       = tws_sladdr_t'(rxByte);
   assign lastBit      = bitCnt_ff == `TWS_LAST_BIT;
   assign ackSlot      = bitCnt_ff == `TWS_ACK_SLOT;
   assign saMatch      = (slAddr.devType == DEV_TYPE) // see RULE4
                         && (slAddr.devSel == selS2_ff); // see RULE5
   assign isMasterCode = rxByte[7:3] == `TWS_HS_CODE; // see RULE7
   assign wrAllowed    = !wpS2_ff; // see RULE18
   assign masterAck    = !sda_i; // see RULE3

   // Acknowledge decision for the byte whose eighth bit is on the line.
   // There is no busy state, so a matching address is always taken.
   assign ackDecide = (state_ff == TWS_ST_SLADDR) ? saMatch : // see RULE17
                      (state_ff == TWS_ST_ADRHI)  ? 1'b1 :
                      (state_ff == TWS_ST_ADRLO)  ? 1'b1 :
                      (state_ff == TWS_ST_WRDATA) ? wrAllowed : // see RULE14
                      1'b0;

   assign memWrite = lastBit && (state_ff == TWS_ST_WRDATA) && wrAllowed; // see RULE16
   assign addrInc  = lastBit && ((state_ff == TWS_ST_RDDATA) || memWrite); // see RULE11 see RULE19
   assign addrLoad = lastBit && (state_ff == TWS_ST_ADRLO); // see RULE9
   assign addrPlus = addrLatch_ff + {{(ADDR_W-1){1'b0}}, 1'b1}; // see RULE12

   // Fetch the next read byte in the ack slot of the address byte or of
   // any byte the master acknowledged; the latch already points past it.
   assign txLoad = ackSlot && (((state_ff == TWS_ST_SLADDR) && ackNext_ff
                                && dirRead_ff) // see RULE20
                               || ((state_ff == TWS_ST_RDDATA)
                                   && masterAck)); // see RULE3

   always_comb begin
      nxt_state = state_ff;
      if (ackSlot) begin
         case (state_ff)
            TWS_ST_SLADDR: begin
               // see RULE6
               nxt_state = !ackNext_ff ? TWS_ST_IGNORE :
                           dirRead_ff  ? TWS_ST_RDDATA : TWS_ST_ADRHI;
            end
            TWS_ST_ADRHI: begin
               nxt_state = TWS_ST_ADRLO;
            end
            TWS_ST_ADRLO: begin
               nxt_state = TWS_ST_WRDATA;
            end
            TWS_ST_WRDATA: begin
               // Protected writes are refused, which ends the write.
               nxt_state = ackNext_ff ? TWS_ST_WRDATA : TWS_ST_IGNORE; // see RULE2 see RULE13
            end
            TWS_ST_RDDATA: begin
               nxt_state = masterAck ? TWS_ST_RDDATA : TWS_ST_IGNORE; // see RULE3 see RULE13
            end
            default: begin
               nxt_state = TWS_ST_IGNORE;
            end
         endcase
      end
   end

   assign nxt_bitCnt = ackSlot ? `TWS_BITCNT_RST : bitCnt_ff + 4'h1;

   always_ff @(posedge scl or negedge engRstN_ff) begin
      if (!engRstN_ff) begin
         state_ff  <= TWS_ST_SLADDR;
         bitCnt_ff <= `TWS_BITCNT_RST;
         rxSh_ff   <= 8'h00;
      end else begin
         state_ff  <= nxt_state;
         bitCnt_ff <= nxt_bitCnt;
         rxSh_ff   <= rxByte;
      end
   end

   always_ff @(posedge scl or negedge engRstN_ff) begin
      if (!engRstN_ff) begin
         ackNext_ff <= 1'b0;
         dirRead_ff <= 1'b0;
      end else if (lastBit) begin
         ackNext_ff <= ackDecide;
         dirRead_ff <= slAddr.dirRead;
      end
   end

   always_ff @(posedge scl or negedge engRstN_ff) begin
      if (!engRstN_ff) begin
         txSh_ff <= 8'h00;
      end else if (txLoad) begin
         txSh_ff <= memArray[addrLatch_ff];
      end
   end

   // Unless ADDR_W is 16, the upper address byte carries more bits than the array needs; the
   // excess is dropped.
   always_ff @(posedge scl or negedge engRstN_ff) begin
      if (!engRstN_ff) begin
         addrHi_ff <= {HI_W{1'b0}};
      end else if (lastBit && (state_ff == TWS_ST_ADRHI)) begin
         addrHi_ff <= rxByte[HI_W-1:0];
      end
   end

   // The latch survives starts, stops and aborts; only power-on clears it.
   always_ff @(posedge scl or negedge porRstN_ff) begin
      if (!porRstN_ff) begin
         addrLatch_ff <= ADDR_W'(`TWS_ADDR_RST); // see RULE25
      end else if (addrLoad) begin
         addrLatch_ff <= {addrHi_ff, rxByte}; // see RULE10
      end else if (addrInc) begin
         addrLatch_ff <= addrPlus; // see RULE11 see RULE12
      end
   end

   // Writing at the eighth bit means a start or stop before it leaves
   // the array untouched, as the byte is never committed.
   always_ff @(posedge scl) begin
      if (memWrite) begin
         memArray[addrLatch_ff] <= rxByte; // see RULE16
      end
   end

   // Master codes are not acknowledged; the mode lasts until a stop.
   always_ff @(posedge scl or negedge hsRstN_ff) begin
      if (!hsRstN_ff) begin
         hsMode_ff <= 1'b0;
      end else if (lastBit && (state_ff == TWS_ST_SLADDR) && isMasterCode) begin
         hsMode_ff <= 1'b1; // see RULE7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: data line driver, updated on the falling edge of scl.
   ////////////////////////////////////////////////////////////////////////

   assign txIdx    = 3'h7 - bitCnt_ff[2:0]; // see RULE15
   assign txBit    = txSh_ff[txIdx];
   // The ack slot of a read byte is left free for the master.
   assign driveLow = (ackSlot && ackNext_ff) // see RULE1 see RULE14
                     || ((state_ff == TWS_ST_RDDATA) && !ackSlot
                         && !txBit); // see RULE3 see RULE22

   always_ff @(negedge scl or negedge engRstN_ff) begin
      if (!engRstN_ff) begin
         sdaOe_ff <= 1'b0;
      end else begin
         sdaOe_ff <= driveLow;
      end
   end

   assign sda_o  = 1'b0;
   assign sda_oe = sdaOe_ff;

   ////////////////////////////////////////////////////////////////////////
   // High speed indication back into the reference domain.
   ////////////////////////////////////////////////////////////////////////

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hsS1_ff <= 1'b0;
         hsS2_ff <= 1'b0;
      end else begin
         hsS1_ff <= hsMode_ff;
         hsS2_ff <= hsS1_ff;
      end
   end

   assign hsMode = hsS2_ff; // see RULE8

endmodule : tws_mem_slave

`default_nettype wire

// ### test/tws_mem_slave_monitor.sv
// Pin-level checks for the two-wire memory slave.
// Assumes an idle-high bus and bus edges kept off ref_clk edges.
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////
module tws_mem_slave_monitor
   import tws_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       scl,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic [2:0] device_select_pins,
   input wire logic       wp,
   input wire logic       hsMode
);
   logic      sclQ_ff;
   logic      sdaQ_ff;
   logic      inFrame_ff;
   wire logic startSeen = sclQ_ff & scl & sdaQ_ff & ~sda_i;
   wire logic stopSeen  = sclQ_ff & scl & ~sdaQ_ff & sda_i;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sclQ_ff    <= 1'b1;
         sdaQ_ff    <= 1'b1;
         inFrame_ff <= 1'b0;
      end else begin
         sclQ_ff    <= scl;
         sdaQ_ff    <= sda_i;
         inFrame_ff <= startSeen | (inFrame_ff & ~stopSeen);
      end
   end
//////////////////////////////////
   a_drv_low:
      assert property (@(posedge ref_clk) disable iff (!rstn) sda_o == 1'b0)
      else $error("data output not low");
   a_oe_scl_low:
      assert property (@(posedge ref_clk) disable iff (!rstn)
         $changed(sda_oe) |-> !scl)
      else $error("drive changed with clock high");
   a_oe_pulls_line:
      assert property (@(posedge scl) disable iff (!rstn) sda_oe |-> !sda_i)
      else $error("driven line not low");
   a_idle_released:
      assert property (@(posedge ref_clk) disable iff (!rstn)
         !inFrame_ff |-> !sda_oe)
      else $error("line driven outside a frame");
   a_start_frees:
      assert property (@(posedge ref_clk) disable iff (!rstn)
         startSeen |=> !sda_oe [*8])
      else $error("line driven after start");
   a_hs_enter:
      assert property (@(posedge ref_clk) disable iff (!rstn)
         $rose(hsMode) |-> scl && inFrame_ff)
      else $error("fast mode entered off a bit");
   a_hs_exit_stop:
      assert property (@(posedge ref_clk) disable iff (!rstn)
         stopSeen && hsMode |-> ##[1:8] !hsMode)
      else $error("fast mode kept after stop");
   a_hs_only_stop:
      assert property (@(posedge ref_clk) disable iff (!rstn)
         $fell(hsMode) |-> !inFrame_ff)
      else $error("fast mode left inside a frame");
   c_hs_on: cover property (@(posedge ref_clk) disable iff (!rstn)
      $rose(hsMode));
   c_hs_stop: cover property (@(posedge ref_clk) disable iff (!rstn)
      stopSeen && hsMode);
   c_drive: cover property (@(posedge scl) disable iff (!rstn) sda_oe);
endmodule : tws_mem_slave_monitor
bind tws_mem_slave tws_mem_slave_monitor mon (.ref_clk(ref_clk),
   .rstn(rstn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .device_select_pins(device_select_pins), .wp(wp), .hsMode(hsMode));
`default_nettype wire

// ### test/tws_bus_master.sv
// Behavioural two-wire bus master that makes the bus clock.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module tws_bus_master #(
   parameter int Q = 80
) (
   output var logic scl,
   output var logic sdaDrv,
   input  wire logic sda
);
   // The clock stands high between frames; data moves a quarter bit
   // away from clock edges so no edge races the slave's sampling.
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic startC();
      sdaDrv = 1'b1;
      #Q scl = 1'b1;
      #Q sdaDrv = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask : startC
   task automatic stopC();
      sdaDrv = 1'b0;
      #Q scl = 1'b1;
      #Q sdaDrv = 1'b1;
      #(2 * Q);
   endtask : stopC
   task automatic bitX(input logic b, output logic r);
      sdaDrv = b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   endtask : bitX
   task automatic rxBits(input int n, input logic [7:0] d,
                         output logic [7:0] q);
      logic b;
      q = 8'hff;
      for (int i = 7; i > 7 - n; i--) begin
         bitX(d[i], b);
         q[i] = b;
      end
   endtask : rxBits
   task automatic byteX(input logic [7:0] d, input logic ackIn,
                        output logic [7:0] q, output logic ak);
      rxBits(8, d, q);
      bitX(ackIn, ak);
   endtask : byteX
endmodule : tws_bus_master
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the two-wire memory slave.
// Assumes the bound pin checker and the behavioural bus master.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import tws_pkg::*;
;
   localparam logic [3:0] DEV_T = 4'h9; // Arbitrary device type code.
   localparam logic [2:0] SEL_V = 3'h5;
   logic       ref_clk;
   logic       rstn;
   logic       wp;
   logic [2:0] pins;
   logic       scl;
   logic       sdaDrv;
   logic       sdaOe;
   logic       sdaO;
   logic       hsMode;
   logic [7:0] q;
   logic       ak;
   int         err_total;
   int         comparisons;
   int         cycles;
   wire logic  sda = sdaDrv & ~(sdaOe & ~sdaO);
   tws_mem_slave #(.ADDR_W(15), .DEV_TYPE(DEV_T)) uut (.ref_clk(ref_clk),
      .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sdaO), .sda_oe(sdaOe),
      .device_select_pins(pins), .wp(wp), .hsMode(hsMode));
   tws_bus_master #(.Q(80)) m (.scl(scl), .sdaDrv(sdaDrv), .sda(sda));
//////////////////////////////////
   function automatic logic [7:0] sla(input logic [2:0] s, input logic r,
                                      input logic [3:0] t = DEV_T);
      tws_sladdr_t a;
      a = '{devType: t, devSel: s, dirRead: r};
      return a;
   endfunction : sla
   function automatic logic [7:0] pat(input int i);
      return 8'h3c ^ 8'(i * 29);
   endfunction : pat
   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : check
   task automatic sendB(input logic [7:0] d, input logic e, input string nm);
      m.byteX(d, 1'b1, q, ak);
      check(nm, 8'(e), 8'(ak));
   endtask : sendB
   task automatic rdB(input logic ackIn, input logic [7:0] e, input string nm);
      m.byteX(8'hff, ackIn, q, ak);
      check(nm, e, q);
   endtask : rdB
   task automatic setAddr(input logic [15:0] a);
      m.startC();
      sendB(sla(SEL_V, 1'b0), 1'b0, "sla_ack");
      sendB(a[15:8], 1'b0, "ahi_ack");
      sendB(a[7:0], 1'b0, "alo_ack");
   endtask : setAddr
   task automatic rdStart();
      m.startC();
      sendB(sla(SEL_V, 1'b1), 1'b0, "rd_sla");
   endtask : rdStart
//////////////////////////////////
   task automatic scWriteRead();
      setAddr(16'h1234);
      for (int i = 0; i < 5; i++) sendB(pat(i), 1'b0, "wr_ack");
      m.stopC();
      setAddr(16'h1234);
      rdStart();
      for (int i = 0; i < 4; i++) rdB(i == 3, pat(i), "rd_seq");
      m.stopC();
      rdStart();
      rdB(1'b1, pat(4), "rd_cur");
      m.stopC();
   endtask : scWriteRead
   // Each pass ends the read in a different legal way, across the wrap.
   task automatic scWrapEnd();
      setAddr(16'hfffe);
      for (int i = 8; i < 13; i++) sendB(pat(i), 1'b0, "wrap_ack");
      m.stopC();
      setAddr(16'h7ffe);
      for (int k = 0; k < 4; k++) begin
         rdStart();
         m.rxBits(8, 8'hff, q);
         check("rd_end", pat(k + 8), q);
         if (k < 2) m.bitX(1'b1, ak);
         if (k == 1 || k == 3) m.startC();
         m.stopC();
      end
      rdStart();
      rdB(1'b1, pat(12), "rd_after");
      m.stopC();
   endtask : scWrapEnd
   task automatic scSelect();
      for (int s = 0; s < 8; s++) begin
         @(negedge ref_clk);
         pins = 3'(s);
         m.startC();
         sendB(sla(SEL_V, 1'b0), 3'(s) != SEL_V, "sel_ack");
         m.stopC();
      end
      @(negedge ref_clk);
      pins = SEL_V;
      m.startC();
      sendB(sla(SEL_V, 1'b0, ~DEV_T), 1'b1, "type_ack");
      m.stopC();
   endtask : scSelect
   task automatic scProtect();
      setAddr(16'h0100);
      sendB(8'h5a, 1'b0, "wp_pre");
      m.stopC();
      @(negedge ref_clk);
      wp = 1'b1;
      setAddr(16'h0100);
      sendB(8'ha5, 1'b1, "wp_nack");
      sendB(8'ha6, 1'b1, "wp_gone");
      m.stopC();
      @(negedge ref_clk);
      wp = 1'b0;
      rdStart();
      rdB(1'b1, 8'h5a, "wp_keep");
      m.stopC();
   endtask : scProtect
   task automatic scAbort();
      setAddr(16'h0200);
      sendB(8'h11, 1'b0, "ab_pre");
      m.stopC();
      setAddr(16'h0200);
      // The stop's own clock rise is the seventh, short of the eighth bit.
      m.rxBits(6, 8'hee, q);
      m.stopC();
      setAddr(16'h0200);
      m.rxBits(3, 8'hee, q);
      rdStart();
      rdB(1'b1, 8'h11, "ab_mem");
      m.stopC();
   endtask : scAbort
   task automatic scFast();
      m.startC();
      sendB(8'h0b, 1'b1, "hs_code");
      check("hs_on", 8'h01, 8'(hsMode));
      setAddr(16'h0300);
      sendB(8'h77, 1'b0, "hs_wr");
      setAddr(16'h0300);
      rdStart();
      rdB(1'b1, 8'h77, "hs_rd");
      m.stopC();
      check("hs_off", 8'h00, 8'(hsMode));
   endtask : scFast
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
//////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      rstn = 1'b0;
      wp = 1'b0;
      pins = SEL_V;
      err_total = 0;
      comparisons = 0;
      cycles = 0;
      repeat (8) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (10) @(negedge ref_clk);
      scWriteRead();
      scWrapEnd();
      scSelect();
      scProtect();
      scAbort();
      scFast();
      final_report();
   end
endmodule : testbench
`default_nettype wire
